// >>> hdl/mctpwm_timer.sv
`timescale 1ns/1ps
module mctpwm_timer (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [mctpwm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // external timer clocks, one per prescaler group
    input wire logic [1:0] external_timer_clock_i,
    // pins and interrupt
    output logic [mctpwm_pkg::NUM_PINS-1:0] timer_wave_output_o,
    output logic irq_o
);
    import mctpwm_pkg::*;

    mctpwm_state_s st; // registered state
    mctpwm_state_s next_st; // next state

    logic [1:0] pre_tick; // prescaler ticks per group
    logic [1:0][3:0] div_tick; // divider taps per group
    logic [1:0] ext_tick; // external clock edges per group
    logic [NUM_TIMERS-1:0] tick; // selected timer clock per timer
    logic [NUM_TIMERS-1:0] zero_evt; // counter reached zero this cycle
    logic [NUM_TIMERS-1:0] dma_mask; // timer routed to dma instead of irq
    logic [NUM_TIMERS-1:0] level_out; // level after inverter
    logic wr_reg; // write to a plain register word
    logic [2:0] bank; // bank of per-timer registers
    logic [2:0] idx; // timer index inside a bank
    logic idx_ok; // index names a timer

    // two shared prescalers, one per group
    mctpwm_clkdiv u_div_a (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .prescale_i(st.pre0),
        .ext_clk_i(external_timer_clock_i[0]),
        .pre_tick_o(pre_tick[0]),
        .div_tick_o(div_tick[0]),
        .ext_tick_o(ext_tick[0])
    );

    mctpwm_clkdiv u_div_b (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .prescale_i(st.pre1),
        .ext_clk_i(external_timer_clock_i[1]),
        .pre_tick_o(pre_tick[1]),
        .div_tick_o(div_tick[1]),
        .ext_tick_o(ext_tick[1])
    );

    // per-timer clock selection and dma routing
    for (genvar n = 0; n < NUM_TIMERS; n++) begin : g_sel
        localparam int unsigned GRP = (n < 2) ? 0 : 1; // prescaler group
        logic [3:0] sel; // divider code of this timer
        assign sel = st.div_sel[n*DIV_SEL_W +: DIV_SEL_W];
        // divider picks tap or external clock
        assign tick[n] = (sel < DIV_SEL_EXT) ? div_tick[GRP][sel[1:0]] : ext_tick[GRP];
        // dma code n+1 silences timer n
        assign dma_mask[n] = (st.dma_sel == 4'(n + 1));
        // inverter applied after the level flop
        assign level_out[n] = st.level[n] ^ st.ctrl[n*CTRL_W + BIT_INVERT];
    end

    // register address decode
    assign bank = addr_i[7:5];
    assign idx = addr_i[4:2];
    assign idx_ok = (addr_i[1:0] == 2'h0) && (idx < 3'(NUM_TIMERS));
    assign wr_reg = wr_i && (bank == 3'h0);

    // next state: bus writes, reads, counters, interrupts, dead zone
    always_comb begin
        next_st = st;
        zero_evt = '0;
        // read data stands for one cycle after the strobe
        next_st.rdata = 32'h0000_0000;
        if (rd_i) begin
            if (addr_i == OFS_PRESCALER_CONFIG) begin
                next_st.rdata = {8'h00, st.dead_len, st.pre1, st.pre0};
            end else if (addr_i == OFS_DIVIDER_SELECT_CONFIG) begin
                next_st.rdata = {8'h00, st.dma_sel, st.div_sel};
            end else if (addr_i == OFS_TIMER_CONTROL_WORD) begin
                next_st.rdata = {11'h000, st.ctrl};
            end else if (addr_i == OFS_INT_STATUS) begin
                next_st.rdata = {27'h0, st.int_status};
            end else if (addr_i == OFS_INT_MASK) begin
                next_st.rdata = {27'h0, st.int_mask};
            end else if (idx_ok && bank == BANK_COUNT_RELOAD_BUFFER) begin
                next_st.rdata = {16'h0000, st.cntb[idx]};
            end else if (idx_ok && bank == BANK_COMPARE_RELOAD_BUFFER) begin
                next_st.rdata = {16'h0000, st.cmpb[idx]};
            end else if (idx_ok && bank == BANK_DOWN_COUNTER_VALUE) begin
                // live counter, not the reload buffer
                next_st.rdata = {16'h0000, st.cnt[idx]};
            end
        end
        // plain register writes
        if (wr_reg && addr_i == OFS_PRESCALER_CONFIG) begin
            next_st.pre0 = wdata_i[POS_PRE0 +: 8];
            next_st.pre1 = wdata_i[POS_PRE1 +: 8];
            next_st.dead_len = wdata_i[POS_DEAD_LEN +: 8];
        end
        if (wr_reg && addr_i == OFS_DIVIDER_SELECT_CONFIG) begin
            next_st.div_sel = wdata_i[19:0];
            next_st.dma_sel = wdata_i[POS_DMA_SEL +: 4];
        end
        if (wr_reg && addr_i == OFS_TIMER_CONTROL_WORD) begin
            next_st.ctrl = wdata_i[20:0];
        end
        if (wr_reg && addr_i == OFS_INT_MASK) begin
            next_st.int_mask = wdata_i[NUM_TIMERS-1:0];
        end
        // buffer writes never disturb the running period
        if (wr_i && idx_ok && bank == BANK_COUNT_RELOAD_BUFFER) begin
            next_st.cntb[idx] = wdata_i[15:0];
        end
        if (wr_i && idx_ok && bank == BANK_COMPARE_RELOAD_BUFFER) begin
            next_st.cmpb[idx] = wdata_i[15:0];
        end
        // per-timer counting
        for (int n = 0; n < NUM_TIMERS; n++) begin
            next_st.start_q[n] = st.ctrl[n*CTRL_W + BIT_START];
            if (st.ctrl[n*CTRL_W + BIT_UPDATE]) begin
                next_st.cnt[n] = st.cntb[n];
                next_st.cmp[n] = st.cmpb[n];
                next_st.level[n] = 1'b0;
            end else if (st.ctrl[n*CTRL_W + BIT_START] && !st.start_q[n] && st.cnt[n] == RST_WORD) begin
                next_st.cnt[n] = st.cntb[n];
                next_st.cmp[n] = st.cmpb[n];
                next_st.level[n] = 1'b0;
            end else if (st.ctrl[n*CTRL_W + BIT_START] && tick[n]) begin
                // only a running timer counts or reloads
                if (st.cnt[n] != RST_WORD) begin
                    // count down one per timer tick
                    next_st.cnt[n] = st.cnt[n] - 16'h0001;
                    if (st.cnt[n] - 16'h0001 == st.cmp[n]) begin
                        next_st.level[n] = 1'b1;
                    end
                    if (st.cnt[n] == 16'h0001) begin
                        zero_evt[n] = 1'b1;
                    end
                end else if (st.ctrl[n*CTRL_W + BIT_RELOAD]) begin
                    // reload on the tick after zero
                    next_st.cnt[n] = st.cntb[n];
                    next_st.cmp[n] = st.cmpb[n];
                    next_st.level[n] = 1'b0;
                end
                // one-shot holds at zero, no more counting
            end
        end
        // dma timer sets no status; set beats clear
        next_st.int_status = st.int_status & ~((wr_reg && addr_i == OFS_INT_STATUS) ? wdata_i[4:0] : 5'h00);
        next_st.int_status = next_st.int_status | (zero_evt & ~dma_mask);
        // dead zone on timer 0, counted in prescaler A ticks
        next_st.dead_prev = level_out[0];
        if (level_out[0] != st.dead_prev) begin
            next_st.dead_cnt = st.dead_len;
        end else if (pre_tick[0] && st.dead_cnt != RST_BYTE) begin
            next_st.dead_cnt = st.dead_cnt - 8'h01;
        end
        // four pins from timers 0..3 (pin 1 from inverted timer 0 when dead zone is on), timer 4 internal
        next_st.wave = level_out[NUM_PINS-1:0];
        if (st.ctrl[BIT_DEAD_EN]) begin
            // both sides held low during the gap
            next_st.wave[0] = level_out[0] && (next_st.dead_cnt == RST_BYTE) && (level_out[0] == st.dead_prev);
            next_st.wave[1] = !level_out[0] && (next_st.dead_cnt == RST_BYTE) && (level_out[0] == st.dead_prev);
        end
    end

    // state register, synchronous reset
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign rdata_o = st.rdata;
    assign timer_wave_output_o = st.wave;
    assign irq_o = |(st.int_status & st.int_mask);
endmodule // mctpwm_timer

// >>> hdl/mctpwm_pkg.sv
package mctpwm_pkg;
    // sizes
    localparam int unsigned NUM_TIMERS = 5;
    localparam int unsigned NUM_PINS = 4;
    localparam int unsigned ADDR_W = 8;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_PRESCALER_CONFIG = 8'h00;
    localparam logic [7:0] OFS_DIVIDER_SELECT_CONFIG = 8'h04;
    localparam logic [7:0] OFS_TIMER_CONTROL_WORD = 8'h08;
    localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [2:0] BANK_COUNT_RELOAD_BUFFER = 3'h1; // 0x20 + 4*n
    localparam logic [2:0] BANK_COMPARE_RELOAD_BUFFER = 3'h2; // 0x40 + 4*n
    localparam logic [2:0] BANK_DOWN_COUNTER_VALUE = 3'h3; // 0x60 + 4*n, read only
    // prescaler_config fields
    localparam int unsigned POS_PRE0 = 0;
    localparam int unsigned POS_PRE1 = 8;
    localparam int unsigned POS_DEAD_LEN = 16;
    // divider_select_config fields: 4 bits per timer, dma select above
    localparam int unsigned DIV_SEL_W = 4;
    localparam int unsigned POS_DMA_SEL = 20;
    localparam logic [3:0] DIV_SEL_EXT = 4'h4; // codes 0..3 are 1/2..1/16
    // timer_control_bits: 4 bits per timer inside timer_control_word
    localparam int unsigned CTRL_W = 4;
    localparam int unsigned BIT_START = 0;
    localparam int unsigned BIT_UPDATE = 1;
    localparam int unsigned BIT_INVERT = 2;
    localparam int unsigned BIT_RELOAD = 3;
    localparam int unsigned BIT_DEAD_EN = 20;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // one 16-bit count or compare value
    typedef logic [15:0] mctpwm_word_t;

    // whole state of the timer block
    typedef struct packed {
        logic [7:0] pre0;
        logic [7:0] pre1;
        logic [7:0] dead_len;
        logic [19:0] div_sel;
        logic [3:0] dma_sel;
        logic [20:0] ctrl;
        logic [NUM_TIMERS-1:0][15:0] cntb;
        logic [NUM_TIMERS-1:0][15:0] cmpb;
        logic [NUM_TIMERS-1:0][15:0] cnt;
        logic [NUM_TIMERS-1:0][15:0] cmp;
        logic [NUM_TIMERS-1:0] level;
        logic [NUM_TIMERS-1:0] start_q;
        logic [NUM_TIMERS-1:0] int_status;
        logic [NUM_TIMERS-1:0] int_mask;
        logic [7:0] dead_cnt;
        logic dead_prev;
        logic [NUM_PINS-1:0] wave;
        logic [31:0] rdata;
    } mctpwm_state_s;

    // state of one prescaler with its divider
    typedef struct packed {
        logic [7:0] pre_cnt;
        logic [3:0] div_cnt;
        logic pre_tick;
        logic [3:0] div_tick;
        logic ext_prev;
        logic ext_tick;
    } mctpwm_div_s;
endpackage

// >>> hdl/mctpwm_clkdiv.sv
`timescale 1ns/1ps
// one 8-bit prescaler with its 1/2..1/16 divider taps and external tick
module mctpwm_clkdiv (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic [7:0] prescale_i,
    input wire logic ext_clk_i,
    // ticks, one cycle each
    output logic pre_tick_o,
    output logic [3:0] div_tick_o,
    output logic ext_tick_o
);
    import mctpwm_pkg::*;

    mctpwm_div_s st; // registered state
    mctpwm_div_s next_st; // next state

    // prescaler counts down, divider advances on each prescaler tick
    always_comb begin
        next_st = st;
        next_st.pre_tick = 1'b0;
        next_st.div_tick = 4'h0;
        if (st.pre_cnt == 8'h00) begin
            // divide by value plus one
            next_st.pre_cnt = prescale_i;
            next_st.pre_tick = 1'b1;
            next_st.div_cnt = st.div_cnt + 4'h1;
            for (int k = 0; k < 4; k++) begin
                // tap k fires every 2^(k+1) prescaler ticks
                next_st.div_tick[k] = &(st.div_cnt | ~(4'hf >> (3 - k)));
            end
        end else begin
            next_st.pre_cnt = st.pre_cnt - 8'h01;
        end
        // rising edge of the external timer clock
        next_st.ext_prev = ext_clk_i;
        next_st.ext_tick = ext_clk_i & ~st.ext_prev;
    end

    // state register, synchronous reset
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pre_tick_o = st.pre_tick;
    assign div_tick_o = st.div_tick;
    assign ext_tick_o = st.ext_tick;
endmodule // mctpwm_clkdiv

// >>> bench/mctpwm_timer_props.sv
`timescale 1ns/1ps
// port-level checker for the timer block
module mctpwm_timer_props (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [mctpwm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // external clocks, pins and interrupt
    input wire logic [1:0] external_timer_clock_i,
    input wire logic [mctpwm_pkg::NUM_PINS-1:0] timer_wave_output_o,
    input wire logic irq_o
);
    import mctpwm_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // counter reads carry 16 bits only
    a_count_width: assert property (rd_i && addr_i[7:5] == BANK_DOWN_COUNTER_VALUE |=> rdata_o[31:16] == 16'h0)
        else $error("counter read wider than 16 bits");
    // there is no sixth timer behind the counter bank
    a_no_timer5: assert property (rd_i && addr_i == 8'h74 |=> rdata_o == 32'h0)
        else $error("sixth counter slot not zero");
    a_mask_width: assert property (rd_i && addr_i == OFS_INT_MASK |=> rdata_o[31:5] == 27'h0)
        else $error("mask read has bits above the five timers");
    a_status_width: assert property (rd_i && addr_i == OFS_INT_STATUS |=> rdata_o[31:5] == 27'h0)
        else $error("status read has bits above the five timers");
    // a cleared mask silences the request line
    a_irq_masked: assert property (wr_i && addr_i == OFS_INT_MASK && wdata_i[4:0] == 5'h0 |=> !irq_o)
        else $error("interrupt high with every source masked");
    a_irq_status: assert property (irq_o && rd_i && addr_i == OFS_INT_STATUS |=> rdata_o[4:0] != 5'h0)
        else $error("interrupt high with empty status");
    // update with inverter on gives a high pin on timer 3
    a_invert_high: assert property (wr_i && addr_i == OFS_TIMER_CONTROL_WORD && wdata_i[15:12] == 4'b0110
        && !wdata_i[BIT_DEAD_EN] ##1 !wr_i |=> ##1 timer_wave_output_o[3]) else $error("inverted pin not high");
    // update with inverter off gives a low pin on timer 2
    a_update_low: assert property (wr_i && addr_i == OFS_TIMER_CONTROL_WORD && wdata_i[11:8] == 4'b0010
        && !wdata_i[BIT_DEAD_EN] ##1 !wr_i |=> ##1 !timer_wave_output_o[2]) else $error("updated pin not low");
    c_irq_rise: cover property ($rose(irq_o));
    c_status_read: cover property (rd_i && addr_i == OFS_INT_STATUS);
    c_pin_rise: cover property ($rose(timer_wave_output_o[2]));
endmodule // mctpwm_timer_props

bind mctpwm_timer mctpwm_timer_props props_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_timer_clock_i(external_timer_clock_i),
    .timer_wave_output_o(timer_wave_output_o), .irq_o(irq_o));

// >>> bench/mctpwm_load_model.sv
`timescale 1ns/1ps
// far side: external clock source and a load timing each pwm pin
module mctpwm_load_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // pins seen, external clock made
    input wire logic [3:0] wave_i,
    output logic [1:0] ext_clk_o,
    // per-pin rise count, period and high time in clocks
    output logic [3:0][15:0] rises_o,
    output logic [3:0][15:0] period_o,
    output logic [3:0][15:0] high_o
);
    logic [3:0][15:0] since; // clocks since last rise
    logic [3:0] prev; // pin level a cycle ago
    logic [2:0] ext_div; // half-period counter, rising edge every 10 clocks
    // timing of every pin and the free-running external clock
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            {since, prev, ext_div, ext_clk_o, rises_o, period_o, high_o} <= '0;
        end else begin
            ext_div <= (ext_div == 3'h4) ? 3'h0 : ext_div + 3'h1;
            if (ext_div == 3'h4) begin
                ext_clk_o <= ~ext_clk_o;
            end
            prev <= wave_i;
            for (int n = 0; n < 4; n++) begin
                since[n] <= since[n] + 16'h1;
                if (wave_i[n] && !prev[n]) begin
                    rises_o[n] <= rises_o[n] + 16'h1;
                    period_o[n] <= since[n] + 16'h1;
                    since[n] <= 16'h0;
                end
                if (!wave_i[n] && prev[n]) begin
                    high_o[n] <= since[n] + 16'h1;
                end
            end
        end
    end
endmodule // mctpwm_load_model

// >>> bench/mctpwm_timer_tb_top.sv
`timescale 1ns/1ps
// bench: register accesses and pin timing seen by the load model
module mctpwm_timer_tb_top;
    import mctpwm_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [1:0] ext_clk; // from the model
    logic [3:0] wave; // pwm pins
    logic irq;
    logic [3:0][15:0] rises, period, high;
    logic [31:0] got; // last read word
    logic [15:0] r0, frozen;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int p; // expected period
    always #25 mclk_i = ~mclk_i;
    mctpwm_timer dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .external_timer_clock_i(ext_clk), .timer_wave_output_o(wave), .irq_o(irq));
    mctpwm_load_model load_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wave_i(wave), .ext_clk_o(ext_clk),
        .rises_o(rises), .period_o(period), .high_o(high));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one access: w=1 write, w=0 read into got
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge mclk_i);
        got = rdata_o;
        @(posedge mclk_i);
    endtask
    // wait for three fresh rises on one pin
    task automatic settle(input int n);
        r0 = rises[n];
        for (int i = 0; i < 3000 && rises[n] < r0 + 16'h3; i++) begin
            @(posedge mclk_i);
        end
    endtask
    // hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        acc(0, OFS_PRESCALER_CONFIG, 0); check("prescaler reset", got, 32'h0);
        acc(0, 8'h74, 0); check("sixth counter", got, 32'h0);
        // timers 1,2: count 4 compare 2; timer 3: 6/3; timer 4: fff
        for (int n = 1; n < 5; n++) begin
            acc(1, {BANK_COUNT_RELOAD_BUFFER, 5'(4 * n)}, (n == 4) ? 32'hfff : (n == 3) ? 32'h6 : 32'h4);
            acc(1, {BANK_COMPARE_RELOAD_BUFFER, 5'(4 * n)}, (n == 3) ? 32'h3 : 32'h2);
        end
        acc(0, 8'h28, 0); check("count buffer", got, 32'h4);
        acc(1, OFS_INT_MASK, 32'h1f);
        acc(1, OFS_PRESCALER_CONFIG, 32'h0201);
        acc(1, OFS_DIVIDER_SELECT_CONFIG, 32'h0043_0000);
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h000a_2aa0);
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h0009_1990);
        // every divider code on timer 2, last one the external clock
        for (int k = 0; k < 5; k++) begin
            acc(1, OFS_DIVIDER_SELECT_CONFIG, {8'h0, 4'h4, 4'h3, 4'h0, 4'(k), 8'h0});
            settle(2);
            p = (k < 4) ? 15 * (2 << k) : 50;
            check("timer2 period", {16'h0, period[2]}, 32'(p));
            check("timer2 high", {16'h0, high[2]}, 32'(p * 3 / 5));
        end
        check("timer1 period", {16'h0, period[1]}, 32'd20);
        check("timer1 high", {16'h0, high[1]}, 32'd12);
        acc(0, 8'h6c, 0); check("one-shot counter", got, 32'h0);
        check("one-shot pin", {31'h0, wave[3]}, 32'h1);
        // stop all, counter of timer 4 must hold
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h0);
        acc(0, 8'h70, 0);
        frozen = got[15:0];
        repeat (200) @(posedge mclk_i);
        acc(0, 8'h70, 0); check("stopped counter", got, {16'h0, frozen});
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h0001_0000);
        repeat (200) @(posedge mclk_i);
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h0);
        acc(0, 8'h70, 0); check("resumed below", {31'h0, got[15:0] < frozen}, 32'h1);
        acc(0, OFS_INT_STATUS, 0); check("status", {30'h0, got[3:2]}, 32'h1);
        check("irq raised", {31'h0, irq}, 32'h1);
        acc(1, OFS_INT_MASK, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        acc(1, OFS_INT_MASK, 32'h1f);
        acc(1, OFS_INT_STATUS, 32'h1f);
        acc(0, OFS_INT_STATUS, 0); check("status cleared", got, 32'h0);
        check("irq cleared", {31'h0, irq}, 32'h0);
        // manual update with and without inverter
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h6000);
        repeat (3) @(posedge mclk_i);
        check("inverted pin", {31'h0, wave[3]}, 32'h1);
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h0200);
        repeat (3) @(posedge mclk_i);
        check("updated pin", {31'h0, wave[2]}, 32'h0);
        check("inverter off", {31'h0, wave[3]}, 32'h0);
        // dead zone on timer 0: pin 1 carries the inverse, gaps cut the high time
        acc(1, {BANK_COUNT_RELOAD_BUFFER, 5'h00}, 32'h4);
        acc(1, {BANK_COMPARE_RELOAD_BUFFER, 5'h00}, 32'h2);
        acc(1, OFS_PRESCALER_CONFIG, 32'h0001_0201);
        acc(1, OFS_DIVIDER_SELECT_CONFIG, 32'h0);
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h0010_000a);
        acc(1, OFS_TIMER_CONTROL_WORD, 32'h0010_0009);
        settle(0);
        check("timer0 period", {16'h0, period[0]}, 32'd20);
        check("dead gap", {31'h0, high[0] < 16'd12}, 32'h1);
        settle(1);
        check("inverse pin period", {16'h0, period[1]}, 32'd20);
        end_sim();
    end
endmodule // mctpwm_timer_tb_top
